/* src/sram_cycle_decode.sv */
`timescale 1ns/1ps
// Cycle decoder and data path control for a flow-through burst SRAM
module sram_cycle_decode (
  input  wire logic                                clk,
  input  wire logic                                rstn,
  input  wire sram_decode_pkg::ctrl_t              ctrl,
  input  wire sram_decode_pkg::wr_t                wr,
  input  wire logic                                sleepRequest,
  input  wire logic                                outputEnableN,
  input  wire logic                                burstOrderSelect,
  input  wire logic [sram_decode_pkg::ADDR_W-1:0]  addr,
  input  wire logic [sram_decode_pkg::DATA_W-1:0]  dataIn,
  output logic      [sram_decode_pkg::DATA_W-1:0]  dataOut,
  output logic      [sram_decode_pkg::DATA_W-1:0]  dataOe,
  output logic      [sram_decode_pkg::ADDR_W-1:0]  coreAddr,
  output logic                                     coreRead,
  output logic      [sram_decode_pkg::LANES-1:0]   coreLaneWrite,
  output logic      [sram_decode_pkg::DATA_W-1:0]  coreWriteData,
  input  wire logic [sram_decode_pkg::DATA_W-1:0]  coreReadData,
  output sram_decode_pkg::cycle_t                  cycle,
  output logic                                     powerDown,
  output logic                                     asleep
);
  import sram_decode_pkg::*;

  logic   selected, newAccess, procStart, ctrlStart, writeAny, holdWrite;
  logic   counterLoad, counterStep;
  logic [LANES-1:0]   laneWrite;
  logic [BURST_W-1:0] offset;
  cycle_t             cycle_d, cycle_q;
  logic [ADDR_W-1:0]  addr_d, addr_q;
  logic               read_d, read_q;
  logic [LANES-1:0]   lanes_d, lanes_q;
  logic [DATA_W-1:0]  wdata_d, wdata_q;
  logic [1:0]         sleepCnt_d, sleepCnt_q;
  logic               asleep_d, asleep_q;
  logic               procCycle_d, procCycle_q;

  assign selected = !ctrl.primaryChipSelectN && ctrl.depthSelectHigh && !ctrl.depthSelectLowN;

  // Processor strobe is ignored while the primary select is high
  assign procStart = !ctrl.processorAddrStrobeN && !ctrl.primaryChipSelectN;
  // Controller strobe counts unless a live processor strobe outranks it
  assign ctrlStart = !ctrl.controllerAddrStrobeN && !procStart;
  assign newAccess = procStart || ctrlStart;

  // Combined write and lane map
  always_comb begin
    writeAny  = !wr.allBytesWriteN
              || (!wr.byteWriteGateN && !(&wr.laneWriteSelectN));
    laneWrite = '0;
    if (!wr.allBytesWriteN) begin
      laneWrite = '1;
    end else if (!wr.byteWriteGateN) begin
      laneWrite = ~wr.laneWriteSelectN;
    end
  end

  // Sleep entry and exit both take two clocks to settle
  always_comb begin
    sleepCnt_d = sleepCnt_q;
    asleep_d   = asleep_q;
    if (sleepRequest != asleep_q) begin
      if (sleepCnt_q == 2'(SLEEP_CYC - 1)) begin
        asleep_d   = sleepRequest;
        sleepCnt_d = SLEEP_ZERO;
      end else begin
        sleepCnt_d = sleepCnt_q + 2'h1;
      end
    end else begin
      sleepCnt_d = SLEEP_ZERO;
    end
  end

  // Cycle decode
  always_comb begin
    cycle_d     = CYC_IDLE;
    addr_d      = addr_q;
    read_d      = 1'b0;
    lanes_d     = '0;
    wdata_d     = wdata_q;
    procCycle_d = 1'b0;
    counterLoad = 1'b0;
    counterStep = 1'b0;
    holdWrite   = writeAny && !procCycle_q;
    if (sleepRequest || asleep_q) begin
      cycle_d = CYC_SLEEP;
    end else if (newAccess && !selected) begin
      cycle_d = CYC_DESELECT;
    end else if (procStart) begin
      cycle_d     = CYC_BEGIN;
      addr_d      = addr;
      read_d      = 1'b1;
      procCycle_d = 1'b1;
      counterLoad = 1'b1;
    end else if (ctrlStart) begin
      cycle_d     = CYC_BEGIN;
      addr_d      = addr;
      counterLoad = 1'b1;
      if (writeAny) begin
        lanes_d = laneWrite;
        wdata_d = dataIn;
      end else begin
        read_d = 1'b1;
      end
    end else begin
      // Write attempted in the edge after a processor start is still honoured; the
      // controller is expected to wait one edge
      holdWrite = writeAny;
      if (!ctrl.burstAdvanceN) begin
        cycle_d     = CYC_CONTINUE;
        counterStep = 1'b1;
      end else begin
        cycle_d = CYC_SUSPEND;
      end
      if (holdWrite) begin
        lanes_d = laneWrite;
        wdata_d = dataIn;
      end else begin
        read_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cycle_q     <= CYC_IDLE;
      addr_q      <= '0;
      read_q      <= 1'b0;
      lanes_q     <= '0;
      wdata_q     <= '0;
      sleepCnt_q  <= SLEEP_ZERO;
      asleep_q    <= 1'b0;
      procCycle_q <= 1'b0;
    end else begin
      cycle_q     <= cycle_d;
      addr_q      <= addr_d;
      read_q      <= read_d;
      lanes_q     <= lanes_d;
      wdata_q     <= wdata_d;
      sleepCnt_q  <= sleepCnt_d;
      asleep_q    <= asleep_d;
      procCycle_q <= procCycle_d;
    end
  end

  burst_counter u_counter (
    .clk         (clk),
    .rstn        (rstn),
    .load        (counterLoad),
    .step        (counterStep),
    .interleaved (burstOrderSelect),
    .start       (addr[BURST_W-1:0]),
    .offset      (offset)
  );

  // Low address bits follow the burst counter once the burst has begun
  assign coreAddr      = {addr_q[ADDR_W-1:BURST_W], offset};
  assign coreRead      = read_q;
  assign coreLaneWrite = lanes_q;
  assign coreWriteData = wdata_q;
  assign cycle         = cycle_q;
  assign asleep        = asleep_q;
  assign powerDown     = (cycle_q == CYC_DESELECT) || (cycle_q == CYC_SLEEP);
  assign dataOut       = coreReadData;

  // Enable is asynchronous on purpose: it gates the pins without a clock edge
  always_comb begin
    dataOe = '0;
    if (read_q && !outputEnableN && !sleepRequest && !asleep_q) begin
      dataOe = '1;
    end
  end
endmodule : sram_cycle_decode

/* shared/sram_decode_pkg.sv */
// Cycle decoder constants, types and contract for the burst SRAM front end
package sram_decode_pkg;
  localparam int ADDR_W   = 19;
  localparam int LANES    = 4;
  localparam int LANE_W   = 8;
  localparam int DATA_W   = LANES * LANE_W;
  localparam int BURST_W  = 2;
  localparam int SLEEP_CYC = 2;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [1:0] SLEEP_ZERO = 2'h0;

  typedef enum logic [5:0] {
    CYC_IDLE     = 6'h01,
    CYC_DESELECT = 6'h02,
    CYC_BEGIN    = 6'h04,
    CYC_CONTINUE = 6'h08,
    CYC_SUSPEND  = 6'h10,
    CYC_SLEEP    = 6'h20
  } cycle_t;

  typedef struct packed {
    logic primaryChipSelectN;
    logic depthSelectHigh;
    logic depthSelectLowN;
    logic processorAddrStrobeN;
    logic controllerAddrStrobeN;
    logic burstAdvanceN;
  } ctrl_t;

  typedef struct packed {
    logic             allBytesWriteN;
    logic             byteWriteGateN;
    logic [LANES-1:0] laneWriteSelectN;
  } wr_t;
endpackage : sram_decode_pkg

/* src/burst_counter.sv */
`timescale 1ns/1ps
// Two-bit wraparound burst counter with linear or interleaved order
module burst_counter (
  input  wire logic                                clk,
  input  wire logic                                rstn,
  input  wire logic                                load,
  input  wire logic                                step,
  input  wire logic                                interleaved,
  input  wire logic [sram_decode_pkg::BURST_W-1:0] start,
  output logic      [sram_decode_pkg::BURST_W-1:0] offset
);
  import sram_decode_pkg::*;
  logic [BURST_W-1:0] base_q, base_d, count_q, count_d;

  always_comb begin
    base_d  = base_q;
    count_d = count_q;
    if (load) begin
      base_d  = start;
      count_d = '0;
    end else if (step) begin
      count_d = count_q + BURST_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      base_q  <= '0;
      count_q <= '0;
    end else begin
      base_q  <= base_d;
      count_q <= count_d;
    end
  end

  // Interleave is an XOR of the step count, linear is a sum mod four
  assign offset = interleaved ? (base_q ^ count_q) : (base_q + count_q);
endmodule : burst_counter

/* verification/cycle_checker.sv */
// Port assertions for the burst SRAM cycle decoder
`timescale 1ns/1ps
module cycle_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire sram_decode_pkg::ctrl_t ctrl,
  input wire sram_decode_pkg::wr_t wr,
  input wire logic sleepRequest,
  input wire logic outputEnableN,
  input wire logic [31:0] dataOe,
  input wire logic [18:0] coreAddr,
  input wire logic coreRead,
  input wire logic [3:0] coreLaneWrite,
  input wire sram_decode_pkg::cycle_t cycle,
  input wire logic powerDown,
  input wire logic asleep
);
  import sram_decode_pkg::*;
  logic armed_q;
  // The release edge still samples reset-time state, so wait one edge
  always_ff @(posedge clk) armed_q <= rstn;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !armed_q);
  // Sleep outranks every other decode, so the decode and read-drive checks are gated by it
  wire act = !sleepRequest && !asleep;
  wire sel = !ctrl.primaryChipSelectN && ctrl.depthSelectHigh && !ctrl.depthSelectLowN;
  wire pst = !ctrl.processorAddrStrobeN && !ctrl.primaryChipSelectN;
  wire cst = !ctrl.controllerAddrStrobeN;
  wire wa = !wr.allBytesWriteN || (!wr.byteWriteGateN && !(&wr.laneWriteSelectN));
  a_deselect_power: assert property (act && (cst || pst) && !sel |=>
    cycle == CYC_DESELECT && powerDown) else $error("deselect missed");
  a_proc_read: assert property (act && sel && pst |=>
    cycle == CYC_BEGIN && coreRead && coreLaneWrite == 4'h0) else $error("start not a read");
  a_ctrl_write: assert property (act && sel && !pst && cst && wa |=> !coreRead &&
    coreLaneWrite == ($past(wr.allBytesWriteN) ? ~$past(wr.laneWriteSelectN) : 4'hF))
    else $error("lane strobes wrong");
  a_burst_step: assert property (act && !cst && !pst && !ctrl.burstAdvanceN |=>
    cycle == CYC_CONTINUE && coreAddr[1:0] != $past(coreAddr[1:0])) else $error("no step");
  a_burst_hold: assert property (act && !cst && !pst && ctrl.burstAdvanceN |=>
    cycle == CYC_SUSPEND && $stable(coreAddr)) else $error("burst address moved");
  a_write_float: assert property (coreLaneWrite != 4'h0 |-> dataOe == 32'h0)
    else $error("data driven during write");
  a_read_drive: assert property (coreRead && !outputEnableN && act |-> dataOe == '1)
    else $error("read data not driven");
  a_sleep_entry: assert property ($rose(asleep) |->
    $past(sleepRequest, 2) && $past(sleepRequest)) else $error("sleep entered early");
endmodule : cycle_checker
bind sram_cycle_decode cycle_checker u_chk (.clk, .rstn, .ctrl, .wr, .sleepRequest,
  .outputEnableN, .dataOe, .coreAddr, .coreRead, .coreLaneWrite, .cycle, .powerDown, .asleep);

/* verification/core_mem_model.sv */
// Memory core stand-in: sixteen words with byte-lane writes
`timescale 1ns/1ps
module core_mem_model (
  input  wire logic        clk,
  input  wire logic [18:0] coreAddr,
  input  wire logic [3:0]  coreLaneWrite,
  input  wire logic [31:0] coreWriteData,
  output logic      [31:0] coreReadData
);
  logic [31:0] mem_q [16];
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (coreLaneWrite[i]) mem_q[coreAddr[3:0]][i*8+:8] <= coreWriteData[i*8+:8];
    end
  end
  // Unwritten words stay unknown, so a stale read never matches
  assign coreReadData = mem_q[coreAddr[3:0]];
endmodule : core_mem_model

/* verification/tb_top.sv */
// Directed bench for the burst SRAM cycle decoder
`timescale 1ns/1ps
module tb_top;
  import sram_decode_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, sleepRequest = 1'h0;
  logic outputEnableN = 1'h0, burstOrderSelect = 1'h1, coreRead, powerDown, asleep;
  ctrl_t ctrl = 6'h17;
  wr_t wr = 6'h3F;
  logic [18:0] addr = 19'h0, coreAddr;
  logic [31:0] dataIn = 32'hA5C30F96, dataOut, dataOe, coreWriteData, coreReadData;
  logic [3:0] coreLaneWrite;
  cycle_t cycle;
  int err_total = 0, samples_checked = 0;
  always #20 clk = ~clk;
  sram_cycle_decode u_dut (.clk, .rstn, .ctrl, .wr, .sleepRequest, .outputEnableN,
    .burstOrderSelect, .addr, .dataIn, .dataOut, .dataOe, .coreAddr, .coreRead,
    .coreLaneWrite, .coreWriteData, .coreReadData, .cycle, .powerDown, .asleep);
  core_mem_model u_core (.clk, .coreAddr, .coreLaneWrite, .coreWriteData, .coreReadData);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One decoded edge, then strobes go quiet so no start is decoded twice
  task automatic step(input ctrl_t c, input wr_t w, input logic [18:0] a);
    @(posedge clk);
    ctrl <= c;
    wr <= w;
    addr <= a;
    @(posedge clk);
    ctrl <= 6'h17;
    wr <= 6'h3F;
    #1;
  endtask : step
  task automatic summarize();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    #1;
    chk({cycle, asleep, coreRead, coreLaneWrite, powerDown, coreAddr}, {CYC_IDLE, 26'h0});
    step(6'h13, 6'h00, 19'h12);
    chk({cycle, coreRead, coreLaneWrite}, {CYC_BEGIN, 5'h10});
    chk({coreAddr, dataOe[0]}, {19'h12, 1'h1});
    step(6'h16, 6'h3F, 19'h0);
    chk(coreAddr, 19'h13);
    step(6'h16, 6'h3F, 19'h0);
    chk({cycle, coreAddr}, {CYC_CONTINUE, 19'h10});
    @(posedge clk);
    outputEnableN <= 1'h1;
    #1;
    chk(dataOe, 32'h0);
    $display("test interleaved done");
    @(posedge clk);
    outputEnableN <= 1'h0;
    burstOrderSelect <= 1'h0;
    step(6'h13, 6'h3F, 19'h7);
    step(6'h16, 6'h3F, 19'h0);
    chk(coreAddr, 19'h4);
    step(6'h17, 6'h3F, 19'h0);
    chk({cycle, coreAddr}, {CYC_SUSPEND, 19'h4});
    $display("test linear done");
    for (int v = 0; v < 16; v++) begin
      step(6'h15, {2'h2, v[3:0]}, 19'h9);
      chk({coreRead, coreLaneWrite, dataOe[0]}, {v == 15, ~v[3:0], v == 15});
    end
    step(6'h15, 6'h07, 19'h9);
    chk({coreLaneWrite, dataOe[0]}, 5'h1E);
    chk(coreWriteData, dataIn);
    step(6'h13, 6'h3F, 19'h1);
    step(6'h16, 6'h1F, 19'h0);
    chk({cycle, coreLaneWrite, coreAddr}, {CYC_CONTINUE, 4'hF, 19'h2});
    step(6'h17, 6'h2E, 19'h0);
    chk({cycle, coreLaneWrite, coreAddr}, {CYC_SUSPEND, 4'h1, 19'h2});
    $display("test writes done");
    step(6'h35, 6'h00, 19'h5);
    chk({cycle, powerDown, dataOe[0]}, {CYC_DESELECT, 2'h2});
    step(6'h03, 6'h3F, 19'h5);
    chk(cycle, CYC_DESELECT);
    step(6'h31, 6'h3F, 19'h5);
    chk({cycle, powerDown}, {CYC_DESELECT, 1'h1});
    @(posedge clk);
    ctrl <= 6'h37;
    sleepRequest <= 1'h1;
    #1;
    chk(dataOe, 32'h0);
    @(posedge clk);
    #1;
    chk(asleep, 1'h0);
    @(posedge clk);
    #1;
    chk({cycle, asleep}, {CYC_SLEEP, 1'h1});
    @(posedge clk);
    sleepRequest <= 1'h0;
    @(posedge clk);
    #1;
    chk(asleep, 1'h1);
    @(posedge clk);
    #1;
    chk(asleep, 1'h0);
    step(6'h13, 6'h3F, 19'h9);
    chk(dataOut, dataIn);
    $display("test sleep done");
    summarize();
  end
endmodule : tb_top
